// >>> shared/eab_pkg.sv
// Package: constants and types for the address and bit-operation cycle accounting block
package eab_pkg;

	// ----------------------------------------
	// Addressing mode codes
	// ----------------------------------------
	typedef enum logic [4:0] {
		EAB_M_DREG = 5'h00,
		EAB_M_AREG = 5'h01,
		EAB_M_IND = 5'h02,
		EAB_M_POSTINC = 5'h03,
		EAB_M_PREDEC = 5'h04,
		EAB_M_D16 = 5'h05,
		EAB_M_ABS_W = 5'h06,
		EAB_M_ABS_L = 5'h07,
		EAB_M_D8_IDX = 5'h08,
		EAB_M_D16_IDX = 5'h09,
		EAB_M_B = 5'h0a,
		EAB_M_D16_B = 5'h0b,
		EAB_M_D32_B = 5'h0c,
		EAB_M_MI_B = 5'h0d,
		EAB_M_MI_B_D16 = 5'h0e,
		EAB_M_MI_B_D32 = 5'h0f,
		EAB_M_MI_D16B = 5'h10,
		EAB_M_MI_D16B_D16 = 5'h11,
		EAB_M_MI_D16B_D32 = 5'h12,
		EAB_M_MI_D32B = 5'h13,
		EAB_M_MI_D32B_D16 = 5'h14,
		EAB_M_MI_D32B_D32 = 5'h15
	} eab_mode_t;

	localparam int EAB_NUM_MODES = 22;

	// Cost column selection
	typedef enum logic [1:0] {
		EAB_COL_BEST = 2'h0,
		EAB_COL_CACHE = 2'h1,
		EAB_COL_WORST = 2'h2
	} eab_col_t;

	// Bit operation kinds
	typedef enum logic [1:0] {
		EAB_OP_TEST = 2'h0,
		EAB_OP_CHANGE = 2'h1,
		EAB_OP_CLEAR = 2'h2,
		EAB_OP_SET = 2'h3
	} eab_op_t;

	// Request kinds
	typedef enum logic [1:0] {
		EAB_REQ_EA = 2'h0,
		EAB_REQ_BIT_REG = 2'h1,
		EAB_REQ_BIT_MEM_REG = 2'h2,
		EAB_REQ_BIT_MEM_IMM = 2'h3
	} eab_req_t;

	// ----------------------------------------
	// Widths and bit-operation costs
	// ----------------------------------------
	localparam int EAB_CLK_W = 6;
	localparam int EAB_CNT_W = 2;
	localparam int EAB_ENTRY_W = EAB_CLK_W + 3 * EAB_CNT_W;
	// Reported prefetches: worst memory bit op plus deepest address prefetches needs one more bit
	localparam int EAB_PF_W = EAB_CNT_W + 1;
	localparam logic [EAB_CLK_W-1:0] EAB_BIT_REG_BEST = 6'h01;
	localparam logic [EAB_CLK_W-1:0] EAB_BIT_REG_CACHE = 6'h04;
	localparam logic [EAB_CLK_W-1:0] EAB_BIT_REG_WORST = 6'h05;
	localparam logic [EAB_CLK_W-1:0] EAB_BIT_MEM_BEST = 6'h04;
	localparam logic [EAB_CLK_W-1:0] EAB_BIT_MEM_CACHE = 6'h04;
	localparam logic [EAB_CLK_W-1:0] EAB_BIT_MEM_WORST = 6'h05;
	localparam logic [EAB_CNT_W-1:0] EAB_BIT_WORST_PF = 2'h1;
	localparam logic [EAB_CNT_W-1:0] EAB_BIT_MEM_WR = 2'h1;

endpackage

// >>> core/eab_cost_rom.sv
// Registered lookup of address calculation cost per mode and column
`timescale 1ns/10ps
module eab_cost_rom (
	input wire logic core_clk, // Clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire eab_pkg::eab_mode_t mode, // Addressing mode
	input wire eab_pkg::eab_col_t col, // Cost column
	output logic [eab_pkg::EAB_ENTRY_W-1:0] entry // {clocks, reads, prefetches, writes}
);
	import eab_pkg::*;

	logic [EAB_ENTRY_W-1:0] next_entry;

	// Table: total clocks with reads, prefetches and writes folded in
	always_comb begin
		next_entry = '0;
		case (mode)
			EAB_M_DREG, EAB_M_AREG: next_entry = {6'h00, 2'h0, 2'h0, 2'h0};
			EAB_M_IND, EAB_M_POSTINC, EAB_M_PREDEC: next_entry = {6'h02, 2'h0, 2'h0, 2'h0};
			EAB_M_D16, EAB_M_ABS_W: next_entry = (col == EAB_COL_WORST) ? {6'h03, 2'h0, 2'h1, 2'h0} :
				{6'h02, 2'h0, 2'h0, 2'h0};
			EAB_M_ABS_L, EAB_M_D8_IDX: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h01, 2'h0, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h04, 2'h0, 2'h0, 2'h0};
					default: next_entry = {6'h05, 2'h0, 2'h1, 2'h0};
				endcase
			end
			EAB_M_D16_IDX, EAB_M_B: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h03, 2'h0, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h06, 2'h0, 2'h0, 2'h0};
					default: next_entry = {6'h07, 2'h0, 2'h1, 2'h0};
				endcase
			end
			EAB_M_D16_B: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h05, 2'h0, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h08, 2'h0, 2'h0, 2'h0};
					default: next_entry = {6'h0a, 2'h0, 2'h1, 2'h0};
				endcase
			end
			EAB_M_D32_B: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h09, 2'h0, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h0c, 2'h0, 2'h0, 2'h0};
					default: next_entry = {6'h0f, 2'h0, 2'h2, 2'h0};
				endcase
			end
			// Memory indirect: one read for the first indirection level only
			EAB_M_MI_B: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h08, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h0b, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h0c, 2'h1, 2'h1, 2'h0};
				endcase
			end
			EAB_M_MI_B_D16, EAB_M_MI_D16B: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h0a, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h0d, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h0f, 2'h1, 2'h1, 2'h0};
				endcase
			end
			EAB_M_MI_B_D32: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h0a, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h0d, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h10, 2'h1, 2'h2, 2'h0};
				endcase
			end
			EAB_M_MI_D16B_D16: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h0c, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h0f, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h12, 2'h1, 2'h2, 2'h0};
				endcase
			end
			EAB_M_MI_D16B_D32: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h0c, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h0f, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h13, 2'h1, 2'h2, 2'h0};
				endcase
			end
			EAB_M_MI_D32B: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h0e, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h11, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h13, 2'h1, 2'h2, 2'h0};
				endcase
			end
			EAB_M_MI_D32B_D16: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h10, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h13, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h15, 2'h1, 2'h2, 2'h0};
				endcase
			end
			EAB_M_MI_D32B_D32: begin
				case (col)
					EAB_COL_BEST: next_entry = {6'h10, 2'h1, 2'h0, 2'h0};
					EAB_COL_CACHE: next_entry = {6'h13, 2'h1, 2'h0, 2'h0};
					default: next_entry = {6'h18, 2'h1, 2'h3, 2'h0};
				endcase
			end
			default: next_entry = '0;
		endcase
	end

	// Registered read data
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			entry <= '0;
		end else begin
			entry <= next_entry;
		end
	end

endmodule

// >>> core/eab_cycle_acct.sv
// Cycle accounting for address calculation and bit operations
`timescale 1ns/10ps
module eab_cycle_acct (
	input wire logic core_clk, // Clock, 50 MHz
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic req_valid, // One-cycle request strobe
	input wire eab_pkg::eab_req_t req_kind, // Address only or bit operation form
	input wire eab_pkg::eab_op_t bit_op, // Bit operation kind
	input wire eab_pkg::eab_mode_t mode, // Addressing mode of memory operand
	input wire logic base_is_index, // Base holds an index register
	input wire logic idx_used, // Index term present
	input wire logic [3:0] base_reg, // Register number used in base
	input wire logic [3:0] index_reg, // Register number used as index
	input wire logic [1:0] index_scale, // Index scale, no timing effect
	input wire logic index_long, // Index size, no timing effect
	input wire logic in_queue, // Instruction words in prefetch queue
	input wire logic in_cache, // Instruction words in cache
	output logic busy, // Lookup in progress
	output logic done, // One-cycle result strobe
	output logic bad_ea, // Illegal base/index combination, with done
	output logic [eab_pkg::EAB_CLK_W-1:0] clocks, // Total clocks
	output logic [eab_pkg::EAB_CNT_W-1:0] reads, // Read cycles
	output logic [eab_pkg::EAB_PF_W-1:0] prefetches, // Prefetch cycles
	output logic [eab_pkg::EAB_CNT_W-1:0] writes // Write cycles
);
	import eab_pkg::*;

	// ----------------------------------------
	// State and captured request
	// ----------------------------------------
	typedef enum logic [1:0] {
		EAB_S_IDLE = 2'h0,
		EAB_S_LOOK = 2'h1,
		EAB_S_SUM = 2'h2
	} eab_state_t;

	eab_state_t state;
	eab_req_t kind_q;
	eab_op_t op_q;
	eab_col_t col_q;
	eab_mode_t mode_q;
	logic bad_q;
	eab_col_t next_col;
	logic next_bad;
	logic [EAB_ENTRY_W-1:0] ea_entry;
	logic [EAB_CLK_W-1:0] base_clk;
	logic [EAB_CNT_W-1:0] base_pf;
	logic [EAB_CNT_W-1:0] base_wr;
	logic [EAB_CLK_W-1:0] ea_clk;
	logic [EAB_CNT_W-1:0] ea_rd;
	logic [EAB_CNT_W-1:0] ea_pf;
	logic [EAB_CNT_W-1:0] ea_wr;

	// Column from where the instruction words live
	always_comb begin
		if (in_queue) begin
			next_col = EAB_COL_BEST;
		end else if (in_cache) begin
			next_col = EAB_COL_CACHE;
		end else begin
			next_col = EAB_COL_WORST;
		end
	end

	// Same index register as base and index is illegal; scale and size unused
	assign next_bad = base_is_index && idx_used && (base_reg == index_reg);

	// Capture the request; base form, scale and size are not part of the key
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			kind_q <= EAB_REQ_EA;
			op_q <= EAB_OP_TEST;
			col_q <= EAB_COL_BEST;
			mode_q <= EAB_M_DREG;
			bad_q <= 1'b0;
		end else if (req_valid && state == EAB_S_IDLE) begin
			kind_q <= req_kind;
			op_q <= bit_op;
			col_q <= next_col;
			mode_q <= mode;
			bad_q <= next_bad;
		end
	end

	// Address cost table
	eab_cost_rom u_rom (
		.core_clk(core_clk),
		.nrst(nrst),
		.mode(mode_q),
		.col(col_q),
		.entry(ea_entry)
	);

	assign ea_clk = ea_entry[EAB_ENTRY_W-1 -: EAB_CLK_W];
	assign ea_rd = ea_entry[3*EAB_CNT_W-1 -: EAB_CNT_W];
	assign ea_pf = ea_entry[2*EAB_CNT_W-1 -: EAB_CNT_W];
	assign ea_wr = ea_entry[EAB_CNT_W-1:0];

	// Bit operation base cost
	always_comb begin
		base_clk = '0;
		base_pf = '0;
		base_wr = '0;
		case (kind_q)
			EAB_REQ_BIT_REG: begin
				case (col_q)
					EAB_COL_BEST: base_clk = EAB_BIT_REG_BEST;
					EAB_COL_CACHE: base_clk = EAB_BIT_REG_CACHE;
					default: begin
						base_clk = EAB_BIT_REG_WORST;
						base_pf = EAB_BIT_WORST_PF;
					end
				endcase
			end
			EAB_REQ_BIT_MEM_REG, EAB_REQ_BIT_MEM_IMM: begin
				case (col_q)
					EAB_COL_BEST: base_clk = EAB_BIT_MEM_BEST;
					EAB_COL_CACHE: base_clk = EAB_BIT_MEM_CACHE;
					default: begin
						base_clk = EAB_BIT_MEM_WORST;
						base_pf = EAB_BIT_WORST_PF;
					end
				endcase
				if (op_q != EAB_OP_TEST) begin
					base_wr = EAB_BIT_MEM_WR;
				end
			end
			default: begin
				base_clk = '0;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= EAB_S_IDLE;
		end else begin
			case (state)
				EAB_S_IDLE: if (req_valid) state <= EAB_S_LOOK;
				EAB_S_LOOK: state <= EAB_S_SUM;
				EAB_S_SUM: state <= EAB_S_IDLE;
				default: state <= EAB_S_IDLE;
			endcase
		end
	end

	// Result outputs; totals hold bus cycles already
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			done <= 1'b0;
			bad_ea <= 1'b0;
			clocks <= '0;
			reads <= '0;
			prefetches <= '0;
			writes <= '0;
		end else begin
			done <= (state == EAB_S_SUM);
			if (state == EAB_S_SUM) begin
				bad_ea <= bad_q;
				if (kind_q == EAB_REQ_BIT_REG) begin
					clocks <= base_clk;
					reads <= '0;
					prefetches <= {1'b0, base_pf};
					writes <= base_wr;
				end else if (kind_q == EAB_REQ_EA) begin
					clocks <= ea_clk;
					reads <= ea_rd;
					prefetches <= {1'b0, ea_pf};
					writes <= ea_wr;
				end else begin
					// Fetch address and fetch immediate address share one table
					clocks <= base_clk + ea_clk;
					reads <= ea_rd;
					// Widened sum: worst case reaches four prefetches
					prefetches <= {1'b0, base_pf} + {1'b0, ea_pf};
					writes <= base_wr + ea_wr;
				end
			end
		end
	end

	// Busy from request until the result strobe, low again while done is high
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			busy <= 1'b0;
		end else begin
			busy <= (state == EAB_S_IDLE) ? req_valid : (state != EAB_S_SUM);
		end
	end

endmodule

// >>> verification/eab_fetch_model.sv
// Partner: instruction fetch state seen by the accounting block
`timescale 1ns/10ps
module eab_fetch_model (
	input wire eab_pkg::eab_col_t col, // Where the instruction words sit
	input wire logic extra, // Words also held in cache
	output logic in_queue, // Words in prefetch queue
	output logic in_cache // Words in cache
);
	import eab_pkg::*;
	// A queue hit may coexist with a cache copy; the queue must still win
	assign in_queue = col == EAB_COL_BEST;
	assign in_cache = col == EAB_COL_CACHE || (in_queue && extra);
endmodule

// >>> verification/eab_cycle_acct_sva.sv
// Checker: timing and cost relations at the accounting block's ports
`timescale 1ns/10ps
module eab_cycle_acct_sva (
	input wire logic core_clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic req_valid, // Request strobe
	input wire eab_pkg::eab_req_t req_kind, // Request kind
	input wire eab_pkg::eab_op_t bit_op, // Bit operation
	input wire eab_pkg::eab_mode_t mode, // Addressing mode
	input wire logic base_is_index, // Base holds index
	input wire logic idx_used, // Index present
	input wire logic [3:0] base_reg, // Base register
	input wire logic [3:0] index_reg, // Index register
	input wire logic [1:0] index_scale, // Scale
	input wire logic index_long, // Size
	input wire logic in_queue, // Queue hit
	input wire logic in_cache, // Cache hit
	input wire logic busy, // Busy
	input wire logic done, // Result strobe
	input wire logic bad_ea, // Illegal form
	input wire logic [eab_pkg::EAB_CLK_W-1:0] clocks, // Clocks
	input wire logic [eab_pkg::EAB_CNT_W-1:0] reads, // Reads
	input wire logic [eab_pkg::EAB_PF_W-1:0] prefetches, // Prefetches
	input wire logic [eab_pkg::EAB_CNT_W-1:0] writes // Writes
);
	import eab_pkg::*;
	logic take;
	// A request counts only while idle
	assign take = req_valid && !busy;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	ans_delay_a: assert property (take |-> ##3 done) else $error("result late");
	busy_span_a: assert property (take |=> busy [*2] ##1 !busy) else $error("busy span");
	done_cause_a: assert property (done |-> $past(take, 3)) else $error("stray result");
	result_hold_a: assert property (!done |-> $stable({bad_ea, clocks, reads, prefetches, writes}))
		else $error("result moved");
	reg_direct_a: assert property (take && req_kind == EAB_REQ_EA && mode <= EAB_M_AREG
		|-> ##3 clocks == 6'h00 && {reads, prefetches, writes} == 7'h00) else $error("direct cost");
	mi_read_a: assert property (done |-> reads == $past(req_kind != EAB_REQ_BIT_REG && mode >= EAB_M_MI_B, 3))
		else $error("read count");
	bad_form_a: assert property (done |-> bad_ea == $past(base_is_index && idx_used && base_reg == index_reg, 3))
		else $error("bad form flag");
	reg_best_a: assert property (take && req_kind == EAB_REQ_BIT_REG && in_queue
		|-> ##3 clocks == 6'h01 && prefetches == 3'h0) else $error("reg best");
	reg_worst_a: assert property (take && req_kind == EAB_REQ_BIT_REG && !in_queue && !in_cache
		|-> ##3 clocks == 6'h05 && prefetches == 3'h1) else $error("reg worst");
	write_cnt_a: assert property (done |-> writes == $past(req_kind[1] && bit_op != EAB_OP_TEST, 3))
		else $error("write count");
	// Main scenarios reached
	cover property (done && bad_ea);
	cover property (done && take);
	cover property (take && req_kind == EAB_REQ_BIT_MEM_IMM && !in_queue && !in_cache);
endmodule
bind eab_cycle_acct eab_cycle_acct_sva i_sva (.core_clk, .nrst, .req_valid, .req_kind, .bit_op, .mode,
	.base_is_index, .idx_used, .base_reg, .index_reg, .index_scale, .index_long, .in_queue, .in_cache,
	.busy, .done, .bad_ea, .clocks, .reads, .prefetches, .writes);

// >>> verification/testbench.sv
// Testbench: self-checking run of the cycle accounting block
`timescale 1ns/10ps
module testbench;
	import eab_pkg::*;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic req_valid = 1'b0, base_is_index = 1'b0, idx_used = 1'b0, index_long = 1'b0, extra = 1'b0;
	logic [3:0] base_reg = 4'h0, index_reg = 4'h0;
	logic [1:0] index_scale = 2'h0;
	eab_req_t req_kind = EAB_REQ_EA;
	eab_op_t bit_op = EAB_OP_TEST;
	eab_mode_t mode = EAB_M_DREG;
	eab_col_t col = EAB_COL_BEST;
	logic in_queue, in_cache, busy, done, bad_ea;
	logic [EAB_CLK_W-1:0] clocks;
	logic [EAB_CNT_W-1:0] reads, writes;
	logic [EAB_PF_W-1:0] prefetches;
	logic [13:0] expq[$];
	logic [15:0] lfsr = 16'h385f;
	logic [15:0] r;
	int n_fail = 0;
	int compares = 0;
	// Address cost per mode: best, cache, worst clocks and worst prefetches
	byte ebst[22] = '{0, 0, 2, 2, 2, 2, 2, 1, 1, 3, 3, 5, 9, 8, 10, 10, 10, 12, 12, 14, 16, 16};
	byte ecch[22] = '{0, 0, 2, 2, 2, 2, 2, 4, 4, 6, 6, 8, 12, 11, 13, 13, 13, 15, 15, 17, 19, 19};
	byte ewst[22] = '{0, 0, 2, 2, 2, 3, 3, 5, 5, 7, 7, 10, 15, 12, 15, 16, 15, 18, 19, 19, 21, 24};
	byte epf[22] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 1, 1, 2, 1, 2, 2, 2, 2, 3};

	always #10 core_clk = ~core_clk;

	eab_fetch_model i_fetch (.col(col), .extra(extra), .in_queue(in_queue), .in_cache(in_cache));
	eab_cycle_acct i_dut (.core_clk(core_clk), .nrst(nrst), .req_valid(req_valid), .req_kind(req_kind),
		.bit_op(bit_op), .mode(mode), .base_is_index(base_is_index), .idx_used(idx_used), .base_reg(base_reg),
		.index_reg(index_reg), .index_scale(index_scale), .index_long(index_long), .in_queue(in_queue),
		.in_cache(in_cache), .busy(busy), .done(done), .bad_ea(bad_ea), .clocks(clocks), .reads(reads),
		.prefetches(prefetches), .writes(writes));

	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction

	task automatic check(input logic [13:0] seen, input logic [13:0] want);
		compares++;
		if (seen !== want) begin
			n_fail++;
			$display("CHECK FAILED %0t: got %h want %h", $time, seen, want);
		end
	endtask

	task automatic finish_test();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Note the expected result, then send one request; hold keeps the strobe up into busy cycles
	task automatic req(input eab_req_t k, input eab_op_t o, input eab_mode_t m, input eab_col_t c,
		input logic bad, input int hold);
		logic [5:0] ck;
		logic [1:0] rd, w;
		logic [2:0] p;
		int e;
		@(posedge core_clk);
		#1;
		rd = k != EAB_REQ_BIT_REG && m >= EAB_M_MI_B;
		e = k == EAB_REQ_BIT_REG ? 0 : (c == EAB_COL_BEST ? ebst[m] : c == EAB_COL_CACHE ? ecch[m] : ewst[m]);
		p = (k != EAB_REQ_BIT_REG && c == EAB_COL_WORST ? epf[m] : 0) + (k != EAB_REQ_EA && c == EAB_COL_WORST);
		ck = e + (k == EAB_REQ_EA ? 0 : k == EAB_REQ_BIT_REG ? (c == EAB_COL_BEST ? 1 : c == EAB_COL_CACHE ? 4 : 5)
			: (c == EAB_COL_WORST ? 5 : 4));
		w = k[1] && o != EAB_OP_TEST;
		expq.push_back({bad, ck, rd, p, w});
		req_kind = k;
		bit_op = o;
		mode = m;
		col = c;
		{extra, index_scale, index_long, base_reg, base_is_index, idx_used} = 10'(rnd());
		// Never zero, so a legal request never reuses the base register as index
		index_reg = base_reg ^ (4'h1 | 4'(rnd()));
		if (bad) begin
			{base_is_index, idx_used, index_reg} = {2'h3, base_reg};
		end
		req_valid = 1'b1;
		repeat (hold + 1) @(posedge core_clk);
		#1;
		req_valid = 1'b0;
		@(posedge core_clk);
	endtask

	// Compare each result with the oldest note
	always @(negedge core_clk) begin
		if (done === 1'b1) begin
			if (expq.size() == 0) check(14'h1, 14'h0);
			else check({bad_ea, clocks, reads, prefetches, writes}, expq.pop_front());
		end
	end

	// Watchdog: about 140 requests of at most 5 cycles each fit well inside 5000 cycles
	initial begin
		#100000;
		n_fail++;
		finish_test();
	end

	initial begin
		repeat (6) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		// Every mode in every column, back to back
		for (int c = 0; c < 3; c++) begin
			for (int m = 0; m < EAB_NUM_MODES; m++) begin
				req(EAB_REQ_EA, EAB_OP_TEST, eab_mode_t'(m), eab_col_t'(c), 1'b0, 0);
			end
		end
		// Register bit operations, every kind in every column
		for (int o = 0; o < 4; o++) begin
			for (int c = 0; c < 3; c++) begin
				req(EAB_REQ_BIT_REG, eab_op_t'(o), eab_mode_t'(rnd() % 22), eab_col_t'(c), 1'b0, 0);
			end
		end
		// Random memory bit operations with illegal forms and ignored extra strobes
		repeat (60) begin
			r = rnd();
			req(eab_req_t'(2 + r[0]), eab_op_t'(r[2:1]), eab_mode_t'(r[15:8] % 22), eab_col_t'(r[4:3] % 3),
				r[6:5] == 2'h0, r[7] ? 2 : 0);
		end
		repeat (5) @(posedge core_clk);
		check(14'(expq.size()), 14'h0);
		finish_test();
	end
endmodule
